/* design/tps_prescaler.sv */
// shared prescaler, general timer control register and two clock selects on apb
`timescale 1ns/1ns
`include "tps_map.svh"
module tps_prescaler
    import tps_pkg::*;
#(
    parameter int PRESC_WIDTH = `TPS_PRESC_WIDTH
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_clock_pin0,
    input wire logic ext_clock_pin1,
    output logic timer_tick0,
    output logic timer_tick1,
    output logic async_prescaler_reset
);
    // elaboration check: the widest tap must fit the counter
    if (PRESC_WIDTH < `TPS_TAP1024) begin : g_bad_width
        $error("prescaler width too small for the divide by 1024 tap");
    end

    typedef struct packed {
        logic [PRESC_WIDTH-1:0] presc;
        logic sync_hold_bit;
        logic async_rst;
        logic sync_rst;
        tps_sel_s sel0;
        tps_sel_s sel1;
        logic [31:0] rdata;
        logic [3:0] tap_pulse;
    } tps_state_s;

    tps_state_s state_r;
    tps_state_s state_nxt;
    logic wr_en;
    logic rd_en;
    logic hit;
    logic [7:0] gtc_val;
    logic [PRESC_WIDTH-1:0] presc_inc;

    // apb access strobes; zero wait state
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;

    // address decode
    always_comb begin
        if (paddr == `TPS_GTC_OFFSET) begin
            hit = 1'b1;
        end else if (paddr == `TPS_SEL0_OFFSET) begin
            hit = 1'b1;
        end else if (paddr == `TPS_SEL1_OFFSET) begin
            hit = 1'b1;
        end else if (paddr == `TPS_STAT_OFFSET) begin
            hit = 1'b1;
        end else begin
            hit = 1'b0;
        end
    end

    // readback image of the general timer control register
    always_comb begin
        gtc_val = `TPS_GTC_RESET;
        gtc_val[`TPS_GTC_HOLD_BIT] = state_r.sync_hold_bit;
        gtc_val[`TPS_GTC_ASYNC_BIT] = state_r.async_rst;
        gtc_val[`TPS_GTC_SYNC_BIT] = state_r.sync_rst;
    end

    assign presc_inc = state_r.presc + {{(PRESC_WIDTH-1){1'b0}}, 1'b1};

    // next state: register writes, reset bit handling, prescaler and taps
    always_comb begin
        state_nxt = state_r;
        // reset bits self-clear unless held
        if (!state_r.sync_hold_bit) begin
            state_nxt.sync_rst = 1'b0;
            state_nxt.async_rst = 1'b0;
        end
        if (wr_en) begin
            if (paddr == `TPS_GTC_OFFSET) begin
                state_nxt.sync_hold_bit = pwdata[`TPS_GTC_HOLD_BIT];
                if (pwdata[`TPS_GTC_HOLD_BIT]) begin
                    // held: keep written values of the reset bits
                    state_nxt.sync_rst = pwdata[`TPS_GTC_SYNC_BIT];
                    state_nxt.async_rst = pwdata[`TPS_GTC_ASYNC_BIT];
                end else begin
                    // hold released: both resets clear together
                    state_nxt.sync_rst = 1'b0;
                    state_nxt.async_rst = 1'b0;
                end
                if (pwdata[`TPS_GTC_SYNC_BIT]) begin
                    state_nxt.presc = '0;
                end
            end else if (paddr == `TPS_SEL0_OFFSET) begin
                state_nxt.sel0.clock_select_field = pwdata[2:0];
            end else if (paddr == `TPS_SEL1_OFFSET) begin
                state_nxt.sel1.clock_select_field = pwdata[2:0];
            end
        end
        // shared free-running count, stopped only by its reset
        if (state_r.sync_rst) begin
            state_nxt.presc = '0;
        end else if (!(wr_en && paddr == `TPS_GTC_OFFSET && pwdata[`TPS_GTC_SYNC_BIT])) begin
            state_nxt.presc = presc_inc;
        end
        // one-cycle tap pulses when the low bits wrap
        state_nxt.tap_pulse[0] = ~state_r.sync_rst & (&state_r.presc[`TPS_TAP8-1:0]);
        state_nxt.tap_pulse[1] = ~state_r.sync_rst & (&state_r.presc[`TPS_TAP64-1:0]);
        state_nxt.tap_pulse[2] = ~state_r.sync_rst & (&state_r.presc[`TPS_TAP256-1:0]);
        state_nxt.tap_pulse[3] = ~state_r.sync_rst & (&state_r.presc[`TPS_TAP1024-1:0]);
        // read data register
        if (rd_en) begin
            if (paddr == `TPS_GTC_OFFSET) begin
                state_nxt.rdata = {24'h000000, gtc_val};
            end else if (paddr == `TPS_SEL0_OFFSET) begin
                state_nxt.rdata = {29'h00000000, state_r.sel0.clock_select_field};
            end else if (paddr == `TPS_SEL1_OFFSET) begin
                state_nxt.rdata = {29'h00000000, state_r.sel1.clock_select_field};
            end else if (paddr == `TPS_STAT_OFFSET) begin
                state_nxt.rdata = 32'h00000000;
                state_nxt.rdata[PRESC_WIDTH-1:0] = state_r.presc;
            end else begin
                state_nxt.rdata = 32'h00000000;
            end
        end
    end

    // single state register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // read data is combinationally muxed in the access phase for zero wait
    always_comb begin
        prdata = 32'h00000000;
        if (rd_en) begin
            if (paddr == `TPS_GTC_OFFSET) begin
                prdata = {24'h000000, gtc_val};
            end else if (paddr == `TPS_SEL0_OFFSET) begin
                prdata = {29'h00000000, state_r.sel0.clock_select_field};
            end else if (paddr == `TPS_SEL1_OFFSET) begin
                prdata = {29'h00000000, state_r.sel1.clock_select_field};
            end else if (paddr == `TPS_STAT_OFFSET) begin
                prdata[PRESC_WIDTH-1:0] = state_r.presc;
            end
        end
    end

    assign async_prescaler_reset = state_r.async_rst;

    // timer 0 source select; pin stability is the software's duty
    tps_tick_sel u_sel0 (
        .clk(clk),
        .resetn(resetn),
        .clock_select_field(state_r.sel0.clock_select_field),
        .tap_pulse(state_r.tap_pulse),
        .ext_clock_pin(ext_clock_pin0),
        .timer_tick(timer_tick0)
    );

    // timer 1 source select sharing the same taps
    tps_tick_sel u_sel1 (
        .clk(clk),
        .resetn(resetn),
        .clock_select_field(state_r.sel1.clock_select_field),
        .tap_pulse(state_r.tap_pulse),
        .ext_clock_pin(ext_clock_pin1),
        .timer_tick(timer_tick1)
    );
endmodule : tps_prescaler

/* design/tps_tick_sel.sv */
// per-timer clock select with external pin synchroniser and edge detector
`timescale 1ns/1ns
`include "tps_map.svh"
module tps_tick_sel
    import tps_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [2:0] clock_select_field,
    input wire logic [3:0] tap_pulse,
    input wire logic ext_clock_pin,
    output logic timer_tick
);
    tps_edge_s state_r;
    tps_edge_s state_nxt;
    logic sel_tick;

    // two-stage sampling then edge detection on the synchronised level
    always_comb begin
        state_nxt = state_r;
        state_nxt.sync_meta = ext_clock_pin;
        state_nxt.sync_out = state_r.sync_meta;
        state_nxt.sync_prev = state_r.sync_out;
        state_nxt.tick = sel_tick;
    end

    // source choice; ext edges bypass the prescaler
    always_comb begin
        case (clock_select_field)
            `TPS_CS_NONE: sel_tick = 1'b0;
            `TPS_CS_SYSCLK: sel_tick = 1'b1;
            `TPS_CS_DIV8: sel_tick = tap_pulse[0];
            `TPS_CS_DIV64: sel_tick = tap_pulse[1];
            `TPS_CS_DIV256: sel_tick = tap_pulse[2];
            `TPS_CS_DIV1024: sel_tick = tap_pulse[3];
            `TPS_CS_EXT_FALL: sel_tick = state_r.sync_prev & ~state_r.sync_out;
            default: sel_tick = state_r.sync_out & ~state_r.sync_prev;
        endcase
    end

    // registered tick: pin edge reaches the counter after about three cycles
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign timer_tick = state_r.tick;
endmodule : tps_tick_sel

/* inc/tps_map.svh */
// register offsets, field positions, reset values and codes of the timer prescaler block
`ifndef TPS_MAP_SVH
`define TPS_MAP_SVH
`define TPS_GTC_OFFSET 12'h000
`define TPS_SEL0_OFFSET 12'h004
`define TPS_SEL1_OFFSET 12'h008
`define TPS_STAT_OFFSET 12'h00c
`define TPS_GTC_HOLD_BIT 7
`define TPS_GTC_ASYNC_BIT 1
`define TPS_GTC_SYNC_BIT 0
`define TPS_GTC_RESET 8'h00
`define TPS_SEL_RESET 3'h0
`define TPS_CS_NONE 3'h0
`define TPS_CS_SYSCLK 3'h1
`define TPS_CS_DIV8 3'h2
`define TPS_CS_DIV64 3'h3
`define TPS_CS_DIV256 3'h4
`define TPS_CS_DIV1024 3'h5
`define TPS_CS_EXT_FALL 3'h6
`define TPS_CS_EXT_RISE 3'h7
`define TPS_TAP8 3
`define TPS_TAP64 6
`define TPS_TAP256 8
`define TPS_TAP1024 10
`define TPS_PRESC_WIDTH 10
`endif

/* inc/tps_pkg.sv */
// types shared by the timer prescaler block
package tps_pkg;
    typedef struct packed {
        logic sync_meta;
        logic sync_out;
        logic sync_prev;
        logic tick;
    } tps_edge_s;
    typedef struct packed {
        logic [2:0] clock_select_field;
    } tps_sel_s;
endpackage : tps_pkg

/* test/tps_prescaler_test.sv */
// self-checking bench for the timer prescaler block
`timescale 1ns/1ns
module tps_prescaler_test
    import tps_pkg::*;
;
    logic clk, resetn, psel, penable, pwrite, pin0, pin1, pready, pslverr, tick0, tick1, arst, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] cnt0, cnt1, s0, s1;
    int err_total = 0;
    int compares = 0;
    int cyc = 0;
    int n, k;
    int taps[4] = '{32'h8, 32'h40, 32'h100, 32'h400};
    tps_prescaler #(.PRESC_WIDTH(10)) tps_prescaler_i (.clk(clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_clock_pin0(pin0), .ext_clock_pin1(pin1),
        .timer_tick0(tick0), .timer_tick1(tick1), .async_prescaler_reset(arst));
    tps_tick_counter tps_tick_counter_i (.clk(clk), .resetn(resetn), .timer_tick(tick0), .count(cnt0));
    tps_tick_counter tps_tick_counter_i1 (.clk(clk), .resetn(resetn), .timer_tick(tick1), .count(cnt1));
    task automatic final_report;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk
    task automatic wt(input int c);
        repeat (c) @(posedge clk);
    endtask : wt
    // read data and error captured with their pre-edge values at the completing edge
    always @(posedge clk) begin
        if (psel && penable && pready) begin
            rd <= prdata;
            err <= pslverr;
        end
    end
    // one apb transfer, data taken at the edge where pready is seen, then one idle cycle
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input logic ee);
        apb(1'b0, a, 32'h0);
        chk(rd, e, "read data");
        chk({31'h0, err}, {31'h0, ee}, "slave error");
    endtask : rdchk
    // ticks of both timers counted over a fixed number of cycles
    task automatic delta(input int c, input logic [15:0] e0, input logic [15:0] e1);
        s0 = cnt0;
        s1 = cnt1;
        wt(c);
        chk({16'h0, cnt0 - s0}, {16'h0, e0}, "timer0 ticks");
        chk({16'h0, cnt1 - s1}, {16'h0, e1}, "timer1 ticks");
    endtask : delta
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            $display("wrong value at %0t: run did not finish", $time);
            final_report;
        end
    end
    initial begin
        {resetn, psel, penable, pwrite, pin0, pin1, paddr, pwdata} = '0;
        wt(2);
        resetn <= 1'b1;
        wt(1);
        for (int i = 0; i < 3; i++) rdchk(12'(4 * i), 32'h0, 1'b0);
        rdchk(12'h010, 32'h0, 1'b1);
        delta(20, 16'h0, 16'h0);
        apb(1'b1, 12'h004, 32'h1);
        wt(1);
        delta(20, 16'h0014, 16'h0);
        apb(1'b1, 12'h008, 32'h2);
        for (int i = 0; i < 4; i++) begin
            n = taps[i];
            apb(1'b1, 12'h004, 32'(i + 2));
            s0 = cnt0;
            k = 0;
            while (cnt0 === s0 && k <= n + 4) begin
                wt(1);
                k++;
            end
            chk({31'h0, k <= n + 2}, 32'h1, "first tap tick");
            delta(2 * n, 16'h2, 16'(n / 4));
        end
        apb(1'b1, 12'h004, 32'h2);
        apb(1'b1, 12'h000, 32'h1);
        rdchk(12'h000, 32'h0, 1'b0);
        apb(1'b0, 12'h00c, 32'h0);
        chk({31'h0, rd[9:0] < 10'h00a}, 32'h1, "prescaler restarted");
        apb(1'b1, 12'h000, 32'h83);
        rdchk(12'h000, 32'h83, 1'b0);
        rdchk(12'h00c, 32'h0, 1'b0);
        chk({31'h0, arst}, 32'h1, "async reset held");
        delta(40, 16'h0, 16'h0);
        apb(1'b1, 12'h000, 32'h0);
        rdchk(12'h000, 32'h0, 1'b0);
        chk({31'h0, arst}, 32'h0, "async reset cleared");
        delta(64, 16'h8, 16'h8);
        apb(1'b1, 12'h004, 32'h7);
        apb(1'b1, 12'h008, 32'h6);
        wt(8);
        s0 = cnt0;
        s1 = cnt1;
        // pins toggle with a half period of three cycles
        for (int i = 0; i < 10; i++) begin
            pin0 <= ~pin0;
            pin1 <= ~pin1;
            wt(3);
        end
        wt(6);
        chk({16'h0, cnt0 - s0}, 32'h5, "rising pin ticks");
        chk({16'h0, cnt1 - s1}, 32'h5, "falling pin ticks");
        final_report;
    end
endmodule : tps_prescaler_test

/* test/tps_properties.sv */
// concurrent checks on the ports of the timer prescaler block
`timescale 1ns/1ns
module tps_properties
    import tps_pkg::*;
#(
    parameter int PRESC_WIDTH = 10
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic ext_clock_pin0,
    input wire logic ext_clock_pin1,
    input wire logic timer_tick0,
    input wire logic timer_tick1,
    input wire logic async_prescaler_reset
);
    logic [2:0] sel0_r;
    logic [2:0] sel1_r;
    logic held_r;
    logic wr;
    logic gtc_wr;
    // shadow of select and hold settings taken from accepted writes
    assign wr = psel && penable && pwrite && pready;
    assign gtc_wr = wr && paddr == 12'h000;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sel0_r <= 3'h0;
            sel1_r <= 3'h0;
            held_r <= 1'b0;
        end else begin
            if (wr && paddr == 12'h004) sel0_r <= pwdata[2:0];
            if (wr && paddr == 12'h008) sel1_r <= pwdata[2:0];
            if (gtc_wr) held_r <= pwdata[7] && pwdata[0];
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    a_ready_now: assert property (psel && penable |-> pready) else $error("slave stalled");
    a_unmapped_err: assert property (psel && penable && paddr > 12'h00c |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_sysclk_tick: assert property (sel0_r == 3'h1 && $stable(sel0_r) |-> timer_tick0)
        else $error("missing system clock tick");
    a_none_quiet: assert property (sel0_r == 3'h0 && $stable(sel0_r) |-> !timer_tick0)
        else $error("tick with no source");
    a_ext_edge: assert property ((sel1_r == 3'h7 && $rose(ext_clock_pin1) || sel1_r == 3'h6 &&
        $fell(ext_clock_pin1)) && $stable(sel1_r) |-> ##[2:4] timer_tick1) else $error("late pin tick");
    a_tap_period: assert property (disable iff (!resetn || psel) sel1_r == 3'h2 && !held_r &&
        timer_tick1 |=> !timer_tick1 [*7] ##1 timer_tick1) else $error("divide by 8 period");
    a_hold_silent: assert property (held_r && $stable(held_r) && sel0_r == 3'h2 |-> !timer_tick0)
        else $error("tick while held");
    a_async_held: assert property (gtc_wr && pwdata[7] && pwdata[1] |=> async_prescaler_reset)
        else $error("held reset bit lost");
    a_async_clear: assert property (gtc_wr && !pwdata[7] |=> !async_prescaler_reset)
        else $error("reset bit not cleared");
    a_sync_clear: assert property (psel && penable && !pwrite && paddr == 12'h000 && !held_r
        |-> !prdata[0]) else $error("sync reset bit stuck");
    // main scenarios reached
    c_tap: cover property (sel1_r == 3'h2 && timer_tick1);
    c_hold: cover property (held_r && gtc_wr);
    c_fall: cover property (sel1_r == 3'h6 && timer_tick1);
endmodule : tps_properties
bind tps_prescaler tps_properties #(.PRESC_WIDTH(PRESC_WIDTH)) tps_properties_i (.clk(clk),
    .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clock_pin0(ext_clock_pin0), .ext_clock_pin1(ext_clock_pin1), .timer_tick0(timer_tick0),
    .timer_tick1(timer_tick1), .async_prescaler_reset(async_prescaler_reset));

/* test/tps_tick_counter.sv */
// tick counting stand-in for one timer counting unit
`timescale 1ns/1ns
module tps_tick_counter
    import tps_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic timer_tick,
    output logic [15:0] count
);
    // advance once for every tick pulse seen at a rising edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) count <= 16'h0000;
        else if (timer_tick) count <= count + 16'h0001;
    end
endmodule : tps_tick_counter
